/* stim_pkg.sv */
// Purpose: constants for the stimulus-3 emulation step
// Assumes: 25 MHz clock
// Notes: register offsets are byte addresses of the internal register port
`default_nettype none
package stim_pkg;
	localparam logic [7:0] timing_select_offset   = 8'h39;
	localparam logic [7:0] response_select_offset = 8'h3A;
	localparam logic [7:0] divider_ratio_offset   = 8'h38;
	localparam logic [7:0] threshold_offset       = 8'h3B;
	localparam logic [7:0] timing_select_reset    = 8'h00;
	localparam logic [7:0] response_select_reset  = 8'h00;
	localparam logic [7:0] threshold_reset        = 8'h00;
	localparam logic [2:0] divider_ratio_reset    = 3'h4;
	localparam int stim_lsb    = 0;
	localparam int timer_lsb   = 3;
	localparam int type_bit    = 6;
	localparam int resp_lsb    = 0;
	localparam int mag_lsb     = 4;
	localparam int thr_lsb     = 0;
	localparam int pupd_lsb    = 4;
	localparam logic [2:0] ratio_reserved = 3'h7;
	localparam logic [3:0] mag_reserved   = 4'hF;
	localparam logic [3:0] thr_reserved   = 4'hF;
	localparam logic [2:0] stim_vbus_ready   = 3'h0;
	localparam logic [2:0] stim_dp_high_a    = 3'h1;
	localparam logic [2:0] stim_dp_window    = 3'h2;
	localparam logic [2:0] stim_dm_high      = 3'h3;
	localparam logic [2:0] stim_reserved_a   = 3'h4;
	localparam logic [2:0] stim_reserved_b   = 3'h5;
	localparam logic [2:0] stim_dp_high_b    = 3'h6;
	localparam logic [2:0] stim_vbus_present = 3'h7;
	localparam logic [3:0] resp_remove   = 4'h0;
	localparam logic [3:0] resp_volt_dp  = 4'h1;
	localparam logic [3:0] resp_volt_dm  = 4'h2;
	localparam logic [3:0] resp_volt_all = 4'h3;
	localparam logic [3:0] resp_res_dp   = 4'h4;
	localparam logic [3:0] resp_rsv_a    = 4'h5;
	localparam logic [3:0] resp_div_dp   = 4'h6;
	localparam logic [3:0] resp_res_dm   = 4'h7;
	localparam logic [3:0] resp_rsv_b    = 4'h8;
	localparam logic [3:0] resp_div_dm   = 4'h9;
	localparam logic [3:0] resp_short    = 4'hA;
	localparam logic [3:0] resp_rsv_c    = 4'hB;
	localparam logic [3:0] resp_div_all  = 4'hC;
	localparam logic [3:0] resp_res_all  = 4'hD;
	localparam logic [3:0] resp_keep_a   = 4'hE;
	localparam logic [3:0] resp_keep_b   = 4'hF;
	localparam int clock_hz     = 25000000;
	localparam int tick_ms      = 1;
	localparam int tick_cycles  = clock_hz / 1000 * tick_ms;
	// delay table, milliseconds per timer code
	localparam logic [6:0] delay_ms_0 = 7'd0;
	localparam logic [6:0] delay_ms_1 = 7'd1;
	localparam logic [6:0] delay_ms_2 = 7'd5;
	localparam logic [6:0] delay_ms_3 = 7'd10;
	localparam logic [6:0] delay_ms_4 = 7'd20;
	localparam logic [6:0] delay_ms_5 = 7'd40;
	localparam logic [6:0] delay_ms_6 = 7'd80;
	localparam logic [6:0] delay_ms_7 = 7'd100;
	typedef enum logic [1:0] {idle_s, wait_s, hold_s, done_s} step_state_t;
endpackage
`default_nettype wire

/* pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous level input
// Notes: output changes once stages two and three agree
`default_nettype none
module pin_sync (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic raw,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;
	always_ff @(posedge clock) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end
endmodule // pin_sync
`default_nettype wire

/* stim_step.sv */
// Purpose: stimulus-3 detection, timer and response sequencing
// Assumes: comparators and supply flags arrive from analog pins
// Notes: reg port writes are checked for reserved codes
//
// Contract
// - divider ratio used only when previous response code is a divider
// - ratio codes 000..110 valid; 111 reserved
// - ratio ignored and not updated while standard profile is active
// - timer type 1: apply at once, hold for timer, remove if stimulus gone
// - timer type 0: timer delays response from detection
// - timer codes select 0,1,5,10,20,40,80,100 ms
// - codes 001,110 positive line high; 011 negative high; 100,101 reserved
// - code 010 window on positive line, above fixed lower bound
// - code 000 satisfied by supply ready; no wait for removal
// - code 111 satisfied by supply present; no wait for removal
// - writes carrying reserved codes are rejected, field keeps value
// - voltage responses: magnitude selects voltage, 1111 reserved
// - resistor responses: magnitude selects resistor, 1111 reserved
// - divider responses: magnitude selects total resistance, 1111 reserved
// - 0000 removes response; 0001..0011 voltage on positive, negative, both
// - 1010 short between lines; 1101 both to ground; 1100 divider both
// - 1110/1111 keep pull-downs for 000, remove for 111, else unchanged
// - single-pin response keeps idle pull-down on other pin under 000
// - threshold ignored for stimulus codes 000 and 111
// - pull-down current select used with pull-down voltage magnitude
`default_nettype none
module stim_step (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       reg_write,
	input  wire logic [7:0] reg_address,
	input  wire logic [7:0] reg_write_data,
	output logic [7:0]      reg_read_data,
	input  wire logic       standard_profile,
	input  wire logic       step_start,
	input  wire logic       dp_above_threshold_pin,
	input  wire logic       dp_above_window_low_pin,
	input  wire logic       dm_above_threshold_pin,
	input  wire logic       vbus_ready_pin,
	input  wire logic       vbus_present_pin,
	input  wire logic [3:0] prev_response_select,
	output logic            step_done,
	output logic [3:0]      comparator_threshold,
	output logic            threshold_used,
	output logic            positive_data_output,
	output logic            negative_data_output,
	output logic            positive_pulldown,
	output logic            negative_pulldown,
	output logic            lines_shorted,
	output logic            divider_on,
	output logic            resistor_on,
	output logic [3:0]      response_magnitude,
	output logic [1:0]      pulldown_current_select,
	output logic            pulldown_current_on,
	output logic [2:0]      prev_divider_ratio,
	output logic            divider_ratio_valid
);
	logic [7:0]  timing_select;
	logic [7:0]  response_config;
	logic [7:0]  threshold_config;
	logic [2:0]  stimulus_select;
	logic [2:0]  stimulus_timer_code;
	logic        timer_behaviour_select;
	logic [3:0]  response_select;
	logic        dp_high;
	logic        dp_window;
	logic        dm_high;
	logic        vbus_ready;
	logic        vbus_present;
	logic        stimulus_seen;
	logic [6:0]  stimulus_timer_value;
	logic [6:0]  ms_count;
	logic [14:0] tick_count;
	logic        tick;
	logic        response_active;
	stim_pkg::step_state_t state;

	pin_sync sync_dp (.clock(clock), .rst(rst), .raw(dp_above_threshold_pin), .level(dp_high));
	pin_sync sync_win (.clock(clock), .rst(rst), .raw(dp_above_window_low_pin),
		.level(dp_window));
	pin_sync sync_dm (.clock(clock), .rst(rst), .raw(dm_above_threshold_pin), .level(dm_high));
	pin_sync sync_rdy (.clock(clock), .rst(rst), .raw(vbus_ready_pin), .level(vbus_ready));
	pin_sync sync_pre (.clock(clock), .rst(rst), .raw(vbus_present_pin), .level(vbus_present));

	assign stimulus_select        = timing_select[stim_pkg::stim_lsb +: 3];
	assign stimulus_timer_code    = timing_select[stim_pkg::timer_lsb +: 3];
	assign timer_behaviour_select = timing_select[stim_pkg::type_bit];
	assign response_select        = response_config[stim_pkg::resp_lsb +: 4];
	assign response_magnitude     = response_config[stim_pkg::mag_lsb +: 4];
	assign comparator_threshold   = threshold_config[stim_pkg::thr_lsb +: 4];
	assign pulldown_current_select = threshold_config[stim_pkg::pupd_lsb +: 2];

	always_ff @(posedge clock) begin
		if (rst) begin
			timing_select <= stim_pkg::timing_select_reset;
		end else if (reg_write && reg_address == stim_pkg::timing_select_offset &&
				reg_write_data[2:0] != stim_pkg::stim_reserved_a &&
				reg_write_data[2:0] != stim_pkg::stim_reserved_b) begin
			timing_select <= {1'b0, reg_write_data[6:0]};
		end
	end

	// reserved magnitude and response codes rejected
	always_ff @(posedge clock) begin
		if (rst) begin
			response_config <= stim_pkg::response_select_reset;
		end else if (reg_write && reg_address == stim_pkg::response_select_offset &&
				reg_write_data[7:4] != stim_pkg::mag_reserved &&
				reg_write_data[3:0] != stim_pkg::resp_rsv_a &&
				reg_write_data[3:0] != stim_pkg::resp_rsv_b &&
				reg_write_data[3:0] != stim_pkg::resp_rsv_c) begin
			response_config <= reg_write_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			threshold_config <= stim_pkg::threshold_reset;
		end else if (reg_write && reg_address == stim_pkg::threshold_offset &&
				reg_write_data[3:0] != stim_pkg::thr_reserved) begin
			threshold_config <= {2'b00, reg_write_data[5:0]};
		end
	end

	// ratio update, frozen under standard profile
	always_ff @(posedge clock) begin
		if (rst) begin
			prev_divider_ratio <= stim_pkg::divider_ratio_reset;
		end else if (reg_write && reg_address == stim_pkg::divider_ratio_offset &&
				!standard_profile && reg_write_data[2:0] != stim_pkg::ratio_reserved) begin
			prev_divider_ratio <= reg_write_data[2:0];
		end
	end

	// ratio valid only for divider responses
	assign divider_ratio_valid = !standard_profile && prev_response_select inside {
		stim_pkg::resp_div_dp, stim_pkg::resp_div_dm, stim_pkg::resp_div_all};

	always_comb begin
		case (reg_address)
			stim_pkg::timing_select_offset: reg_read_data = timing_select;
			stim_pkg::response_select_offset: reg_read_data = response_config;
			stim_pkg::threshold_offset: reg_read_data = threshold_config;
			stim_pkg::divider_ratio_offset: reg_read_data = {5'h00, prev_divider_ratio};
			default: reg_read_data = 8'h00;
		endcase
	end

	// threshold not used for supply stimuli
	assign threshold_used = stimulus_select != stim_pkg::stim_vbus_ready &&
		stimulus_select != stim_pkg::stim_vbus_present;

	always_comb begin
		case (stimulus_select)
			stim_pkg::stim_vbus_ready: stimulus_seen = vbus_ready;
			stim_pkg::stim_dp_high_a: stimulus_seen = dp_high;
			stim_pkg::stim_dp_window: stimulus_seen = !dp_high && dp_window;
			stim_pkg::stim_dm_high: stimulus_seen = dm_high;
			stim_pkg::stim_dp_high_b: stimulus_seen = dp_high;
			stim_pkg::stim_vbus_present: stimulus_seen = vbus_present;
			default: stimulus_seen = 1'b0;
		endcase
	end

	always_comb begin
		case (stimulus_timer_code)
			3'h0: stimulus_timer_value = stim_pkg::delay_ms_0;
			3'h1: stimulus_timer_value = stim_pkg::delay_ms_1;
			3'h2: stimulus_timer_value = stim_pkg::delay_ms_2;
			3'h3: stimulus_timer_value = stim_pkg::delay_ms_3;
			3'h4: stimulus_timer_value = stim_pkg::delay_ms_4;
			3'h5: stimulus_timer_value = stim_pkg::delay_ms_5;
			3'h6: stimulus_timer_value = stim_pkg::delay_ms_6;
			default: stimulus_timer_value = stim_pkg::delay_ms_7;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst || state == stim_pkg::idle_s || tick) begin
			tick_count <= 15'h0000;
		end else begin
			tick_count <= tick_count + 15'h0001;
		end
	end
	assign tick = tick_count == 15'(stim_pkg::tick_cycles - 1);

	always_ff @(posedge clock) begin
		if (rst || state == stim_pkg::idle_s) begin
			ms_count <= 7'h00;
		end else if (tick && ms_count != 7'h7F) begin
			ms_count <= ms_count + 7'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= stim_pkg::idle_s;
		end else begin
			case (state)
				stim_pkg::idle_s: begin
					if (step_start && stimulus_seen) begin
						state <= timer_behaviour_select ? stim_pkg::hold_s : stim_pkg::wait_s;
					end
				end
				stim_pkg::wait_s: begin
					if (ms_count >= stimulus_timer_value) begin
						state <= stim_pkg::done_s;
					end
				end
				stim_pkg::hold_s: begin
					if (ms_count >= stimulus_timer_value) begin
						state <= stim_pkg::done_s;
					end
				end
				stim_pkg::done_s: begin
					if (!step_start) begin
						state <= stim_pkg::idle_s;
					end
				end
				default: state <= stim_pkg::idle_s;
			endcase
		end
	end
	assign step_done = state == stim_pkg::done_s;

	// response held, dropped after hold if non-supply stimulus gone
	always_ff @(posedge clock) begin
		if (rst || !step_start) begin
			response_active <= 1'b0;
		end else if (state == stim_pkg::idle_s && stimulus_seen && timer_behaviour_select) begin
			response_active <= 1'b1;
		end else if (state == stim_pkg::wait_s && ms_count >= stimulus_timer_value) begin
			response_active <= 1'b1;
		end else if (state == stim_pkg::done_s && timer_behaviour_select && !stimulus_seen &&
				threshold_used) begin
			response_active <= 1'b0;
		end
	end

	// drive decode, reset pattern while no response
	always_ff @(posedge clock) begin
		if (rst || !response_active) begin
			positive_data_output <= 1'b0;
			negative_data_output <= 1'b0;
			positive_pulldown    <= 1'b1;
			negative_pulldown    <= 1'b1;
			lines_shorted        <= 1'b0;
			divider_on           <= 1'b0;
			resistor_on          <= 1'b0;
			pulldown_current_on  <= 1'b0;
		end else begin
			lines_shorted <= response_select == stim_pkg::resp_short;
			divider_on <= response_select inside {stim_pkg::resp_div_dp, stim_pkg::resp_div_dm,
				stim_pkg::resp_div_all};
			resistor_on <= response_select inside {stim_pkg::resp_res_dp, stim_pkg::resp_res_dm,
				stim_pkg::resp_res_all};
			pulldown_current_on <= response_magnitude == 4'h0 && response_select inside {
				stim_pkg::resp_volt_dp, stim_pkg::resp_volt_dm, stim_pkg::resp_volt_all};
			case (response_select)
				stim_pkg::resp_remove: begin
					positive_data_output <= 1'b0;
					negative_data_output <= 1'b0;
					positive_pulldown    <= 1'b0;
					negative_pulldown    <= 1'b0;
				end
				stim_pkg::resp_volt_dp, stim_pkg::resp_res_dp, stim_pkg::resp_div_dp: begin
					positive_data_output <= 1'b1;
					positive_pulldown    <= 1'b0;
					negative_pulldown    <= negative_pulldown &&
						stimulus_select == stim_pkg::stim_vbus_ready;
				end
				stim_pkg::resp_volt_dm, stim_pkg::resp_res_dm, stim_pkg::resp_div_dm: begin
					negative_data_output <= 1'b1;
					negative_pulldown    <= 1'b0;
					positive_pulldown    <= positive_pulldown &&
						stimulus_select == stim_pkg::stim_vbus_ready;
				end
				stim_pkg::resp_keep_a, stim_pkg::resp_keep_b: begin
					if (stimulus_select == stim_pkg::stim_vbus_present) begin
						positive_pulldown <= 1'b0;
						negative_pulldown <= 1'b0;
					end
				end
				default: begin
					positive_data_output <= 1'b1;
					negative_data_output <= 1'b1;
					positive_pulldown    <= 1'b0;
					negative_pulldown    <= 1'b0;
				end
			endcase
		end
	end

	// reserved stimulus write leaves field unchanged
	a_stim_reject: assert property (@(posedge clock) disable iff (rst)
		reg_write && reg_address == stim_pkg::timing_select_offset &&
		reg_write_data[2:1] == 2'b10 |=> $stable(timing_select))
		else $error("reserved stimulus code accepted");
	a_ratio_legal: assert property (@(posedge clock) disable iff (rst)
		prev_divider_ratio != stim_pkg::ratio_reserved)
		else $error("ratio holds reserved code");
	a_ratio_frozen: assert property (@(posedge clock) disable iff (rst)
		standard_profile |=> $stable(prev_divider_ratio))
		else $error("ratio changed under standard profile");
	// ratio valid only for divider code
	a_ratio_valid: assert property (@(posedge clock) disable iff (rst)
		divider_ratio_valid |-> prev_response_select inside {4'h6, 4'h9, 4'hC})
		else $error("ratio valid for non-divider code");
	sequence detect_hold_s;
		state == stim_pkg::idle_s && step_start && stimulus_seen && timer_behaviour_select;
	endsequence
	a_hold_apply: assert property (@(posedge clock) disable iff (rst)
		detect_hold_s ##1 step_start |=> response_active)
		else $error("hold response not applied at once");
	a_delay_wait: assert property (@(posedge clock) disable iff (rst)
		state == stim_pkg::wait_s && ms_count < stimulus_timer_value &&
		$past(state) == stim_pkg::wait_s |-> !response_active)
		else $error("response before delay");
	a_thr_ignored: assert property (@(posedge clock) disable iff (rst)
		stimulus_select inside {3'h0, 3'h7} |-> !threshold_used)
		else $error("threshold used for supply stimulus");
	a_short_code: assert property (@(posedge clock) disable iff (rst)
		$rose(lines_shorted) |-> $past(response_select) == stim_pkg::resp_short)
		else $error("short without its code");
endmodule // stim_step
`default_nettype wire

/* attached_device.sv */
// Purpose: attached portable device as seen by the line comparators
// Assumes: the bench requests which comparator and supply levels stand
// Notes: pins move just after the rising edge, like every other bench input
`default_nettype none
module attached_device (
	input  wire logic       clock,
	input  wire logic [4:0] want,
	output logic            dp_high,
	output logic            dp_window,
	output logic            dm_high,
	output logic            vbus_ready,
	output logic            vbus_present
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {dp_high, dp_window, dm_high, vbus_ready, vbus_present} = 5'h00;
	always @(posedge clock) begin
		#1 {dp_high, dp_window, dm_high, vbus_ready, vbus_present} = want;
	end
endmodule // attached_device
`default_nettype wire

/* charger_emulation_stimulus_response_test.sv */
// Purpose: self-checking bench for the stimulus-3 step
// Assumes: 25 MHz clock, one-millisecond tick of 25000 cycles
// Notes: step outputs are sampled once the step reports done; t_hold_release also samples pos while the hold runs
`default_nettype none
module charger_emulation_stimulus_response_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clock = 1'b0;
	logic            rst = 1'b1;
	logic            reg_write = 1'b0;
	logic [7:0]      reg_address = 8'h00;
	logic [7:0]      reg_write_data = 8'h00;
	logic            standard_profile = 1'b0;
	logic            step_start = 1'b0;
	logic [3:0]      prev_response_select = 4'h0;
	logic [4:0]      want = 5'h00;
	wire logic       dp_high, dp_window, dm_high, vbus_ready, vbus_present;
	logic [7:0]      reg_read_data;
	logic            step_done, threshold_used, pos, neg, pdp, pdm, short, div, valid;
	logic            res, pcur;
	logic [3:0]      thr;
	logic [3:0]      mag;
	logic [1:0]      pupd;
	logic [2:0]      ratio;
	int              num_errors = 0;
	int              n_compared = 0;

	always #20 clock = ~clock;

	attached_device attached_device_i (.clock(clock), .want(want), .dp_high(dp_high),
		.dp_window(dp_window), .dm_high(dm_high), .vbus_ready(vbus_ready),
		.vbus_present(vbus_present));

	stim_step stim_step_i (.clock(clock), .rst(rst), .reg_write(reg_write),
		.reg_address(reg_address), .reg_write_data(reg_write_data),
		.reg_read_data(reg_read_data), .standard_profile(standard_profile),
		.step_start(step_start), .dp_above_threshold_pin(dp_high),
		.dp_above_window_low_pin(dp_window), .dm_above_threshold_pin(dm_high),
		.vbus_ready_pin(vbus_ready), .vbus_present_pin(vbus_present),
		.prev_response_select(prev_response_select), .step_done(step_done),
		.comparator_threshold(thr), .threshold_used(threshold_used),
		.positive_data_output(pos), .negative_data_output(neg), .positive_pulldown(pdp),
		.negative_pulldown(pdm), .lines_shorted(short), .divider_on(div), .resistor_on(res),
		.response_magnitude(mag), .pulldown_current_select(pupd), .pulldown_current_on(pcur),
		.prev_divider_ratio(ratio), .divider_ratio_valid(valid));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_write = 1'b1;
		reg_address = a;
		reg_write_data = d;
		@(posedge clock);
		#1 reg_write = 1'b0;
	endtask

	task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		#1 reg_address = a;
		#5 check(what, reg_read_data, exp);
	endtask

	task automatic t_reset();
		rd_check("timing reset", 8'h39, 8'h00);
		rd_check("response reset", 8'h3A, 8'h00);
		rd_check("threshold reset", 8'h3B, 8'h00);
		rd_check("ratio reset", 8'h38, 8'h04);
		rd_check("unmapped", 8'h50, 8'h00);
		check("pulldowns reset", {6'h00, pdp, pdm}, 8'h03);
		$display("done reset values");
	endtask

	task automatic t_fields();
		logic [7:0] bad [4] = '{8'hF1, 8'h25, 8'h28, 8'h2B};
		logic [2:0] stim [3] = '{3'h0, 3'h7, 3'h1};
		wr(8'h39, 8'h01);
		wr(8'h39, 8'h04);
		wr(8'h39, 8'h05);
		rd_check("stim reserved", 8'h39, 8'h01);
		wr(8'h3A, 8'h21);
		for (int i = 0; i < 4; i++)
			wr(8'h3A, bad[i]);
		rd_check("response reserved", 8'h3A, 8'h21);
		check("magnitude view", {4'h0, mag}, 8'h02);
		wr(8'h3B, 8'h05);
		wr(8'h3B, 8'h0F);
		rd_check("threshold reserved", 8'h3B, 8'h05);
		wr(8'h38, 8'h02);
		wr(8'h38, 8'h07);
		rd_check("ratio reserved", 8'h38, 8'h02);
		check("ratio view", {5'h00, ratio}, 8'h02);
		@(posedge clock);
		#1 standard_profile = 1'b1;
		wr(8'h38, 8'h01);
		rd_check("ratio frozen", 8'h38, 8'h02);
		@(posedge clock);
		#1 standard_profile = 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clock);
			#1 prev_response_select = i[3:0];
			#5 check("ratio used", {7'h00, valid}, {7'h00, i == 6 || i == 9 || i == 12});
		end
		for (int i = 0; i < 3; i++) begin
			wr(8'h39, {5'h00, stim[i]});
			#5 check("threshold used", {7'h00, threshold_used}, {7'h00, i == 2});
		end
		wr(8'hF5 == 8'hF5 ? 8'h3B : 8'h3B, 8'hF5);
		#5 check("pulldown current", {2'h0, pupd, thr}, 8'h35);
		$display("done register fields");
	endtask

	task automatic t_step(input logic [7:0] c1, input logic [7:0] c2, input logic [4:0] pins,
		input logic [7:0] exp, input logic [7:0] mask, input int early);
		int n;
		wr(8'h39, c1);
		wr(8'h3A, c2);
		@(posedge clock);
		#1 step_start = 1'b1;
		want = pins;
		n = 0;
		if (early > 0) begin
			repeat (early) @(posedge clock);
			#1 check("early done", {7'h00, step_done}, 8'h00);
		end
		while (step_done !== 1'b1 && n < 30000) begin
			@(posedge clock);
			#1 n++;
		end
		check("step done", {7'h00, step_done}, 8'h01);
		repeat (3) @(posedge clock);
		// vector: res pcur pos neg short div pdp pdm
		#1 check("lines", {res, pcur, pos, neg, short, div, pdp, pdm} & mask, exp & mask);
		step_start = 1'b0;
		want = 5'h00;
		repeat (10) @(posedge clock);
		$display("done step %h %h", c1, c2);
	endtask

	task automatic t_hold_release();
		int n;
		wr(8'h39, 8'h49);
		wr(8'h3A, 8'h01);
		@(posedge clock);
		#1 step_start = 1'b1;
		want = 5'h10;
		repeat (8) @(posedge clock);
		#1 check("hold applied", {7'h00, pos}, 8'h01);
		check("hold running", {7'h00, step_done}, 8'h00);
		want = 5'h00;
		n = 0;
		while (step_done !== 1'b1 && n < 30000) begin
			@(posedge clock);
			#1 n++;
		end
		check("hold length", {7'h00, n > 24900}, 8'h01);
		check("hold kept", {7'h00, pos}, 8'h01);
		repeat (3) @(posedge clock);
		#1 check("hold removed", {7'h00, pos}, 8'h00);
		step_start = 1'b0;
		repeat (10) @(posedge clock);
		$display("done hold release");
	endtask

	initial begin
		repeat (8) @(posedge clock);
		#1 rst = 1'b0;
		t_reset();
		t_fields();
		t_step(8'h01, 8'h01, 5'h10, 8'h60, 8'hF0, 0);
		t_step(8'h46, 8'h52, 5'h10, 8'h10, 8'hF0, 0);
		t_step(8'h03, 8'h0A, 5'h04, 8'h08, 8'hCC, 0);
		t_step(8'h02, 8'h0C, 5'h08, 8'h04, 8'hCC, 0);
		t_step(8'h00, 8'h01, 5'h02, 8'h61, 8'hE1, 0);
		t_step(8'h07, 8'h0E, 5'h01, 8'h00, 8'hC3, 0);
		t_step(8'h09, 8'h34, 5'h10, 8'hA0, 8'hE0, 20000);
		t_hold_release();
		close_out();
	end

	// cut a hang short well past the expected run length
	initial begin
		#(80000 * 40);
		num_errors++;
		close_out();
	end
endmodule // charger_emulation_stimulus_response_test
`default_nettype wire
